// >>> include/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;

    // ----------------------------------------
    // Group widths
    // ----------------------------------------
    localparam int VID_W = 20;
    localparam int STOR_W = 6;
    localparam int FLASH_W = 4;
    localparam int AUD_W = 4;
    localparam int UART_W = 2;
    localparam int ADDR_LO = 2;
    localparam int ADDR_HI = 15;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------
    // Video pad positions
    // ----------------------------------------
    localparam int VID_PAD_DB0 = 0;
    localparam int VID_PAD_DB1 = 1;
    localparam int VID_PAD_CS = 16;
    localparam int VID_PAD_ERD = 17;
    localparam int VID_PAD_RS = 18;
    localparam int VID_PAD_WR = 19;

    // ----------------------------------------
    // Audio and serial pad positions
    // ----------------------------------------
    localparam int AUD_PAD_DATA = 0;
    localparam int AUD_PAD_BCK = 1;
    localparam int AUD_PAD_WS = 2;
    localparam int AUD_PAD_MCLK = 3;
    localparam int UART_PAD_CTS = 0;
    localparam int UART_PAD_RTS = 1;

    // ----------------------------------------
    // Modes and carriers
    // ----------------------------------------
    typedef enum logic {
        MODE_DEFAULT = 1'b0,
        MODE_ALT = 1'b1
    } mode_t;

    typedef struct packed {
        mode_t storage;
        mode_t video;
        mode_t audio;
        mode_t flash;
        mode_t uart;
    } group_sel_t;

    typedef struct packed {
        logic [ADDR_HI:ADDR_LO] address;
        logic staticCs0;
        logic staticCs1;
        logic dramClockOut;
        logic dramClockEnable;
        logic dramChipSelect;
        logic dramDataMask1;
    } ext_bus_t;

    typedef struct packed {
        logic dataB;
        logic dataClock;
        logic frameSync;
        logic dataA;
    } telephony_t;

    // ----------------------------------------
    // Values after reset and idle input levels
    // ----------------------------------------
    localparam group_sel_t SEL_RESET = '{default: MODE_DEFAULT};
    localparam logic [VID_W-1:0] DISP_IDLE = 20'h0_0000;
    localparam logic [STOR_W-1:0] GPIO_IDLE = 6'h00;
    localparam logic [STOR_W-1:0] CARD_LO_IDLE = 6'h3F;
    localparam logic [FLASH_W-1:0] READY_IDLE = 4'hF;
    localparam logic [FLASH_W-1:0] CARD_HI_IDLE = 4'hF;
    localparam logic [AUD_W-1:0] AUD_IDLE = 4'h0;
    localparam logic [AUD_W-1:0] TEL_IDLE = 4'h0;
    localparam logic [UART_W-1:0] UART_IDLE = 2'h3;
    localparam logic [UART_W-1:0] SPI_IDLE = 2'h3;

endpackage
`default_nettype wire

// >>> design/pin_mux_slice.sv
`timescale 1ns/1ps
`default_nettype none
module pin_mux_slice
#(
    parameter int W = 1,
    parameter logic [W-1:0] IDLE_A = '0,
    parameter logic [W-1:0] IDLE_B = '0
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sel,
    input wire logic [W-1:0] aOut,
    input wire logic [W-1:0] aOe,
    input wire logic [W-1:0] bOut,
    input wire logic [W-1:0] bOe,
    input wire logic [W-1:0] padIn,
    output logic [W-1:0] padOut,
    output logic [W-1:0] padOe,
    output logic [W-1:0] aIn,
    output logic [W-1:0] bIn
);
    logic [W-1:0] syncMeta;
    logic [W-1:0] syncPad;
    logic [W-1:0] next_padOut;
    logic [W-1:0] next_padOe;
    logic [W-1:0] next_aIn;
    logic [W-1:0] next_bIn;

    // ----------------------------------------
    // Pad steering
    // ----------------------------------------
    // Deselected side sees its idle level so it cannot act on foreign traffic
    always_comb
    begin
        next_padOut = sel ? bOut : aOut;
        next_padOe = sel ? bOe : aOe;
        next_aIn = sel ? IDLE_A : syncPad;
        next_bIn = sel ? syncPad : IDLE_B;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            syncMeta <= '0;
            syncPad <= '0;
            padOut <= '0;
            padOe <= '0;
            aIn <= IDLE_A;
            bIn <= IDLE_B;
        end
        else
        begin
            syncMeta <= padIn;
            syncPad <= syncMeta;
            padOut <= next_padOut;
            padOe <= next_padOe;
            aIn <= next_aIn;
            bIn <= next_bIn;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_idle_side_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(sel) |-> aIn == IDLE_A)
        else $error("deselected default side not idle");

    chk_idle_side_b: assert property (
        @(posedge clk) disable iff (!rstn)
        $past(rstn) && !$past(sel) |-> bIn == IDLE_B && padOe == $past(aOe))
        else $error("deselected alternate side not idle or not ignored");

endmodule
`default_nettype wire

// >>> design/shared_pin_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_mux
(
    input wire logic clk,
    input wire logic resetn,
    input wire pin_mux_pkg::group_sel_t modeRequest,
    output var pin_mux_pkg::group_sel_t activeMode,
    input wire logic [pin_mux_pkg::VID_W-1:0] videoPadIn,
    output logic [pin_mux_pkg::VID_W-1:0] videoPadOut,
    output logic [pin_mux_pkg::VID_W-1:0] videoPadOe,
    input wire logic [pin_mux_pkg::VID_W-1:0] displayOut,
    input wire logic [pin_mux_pkg::VID_W-1:0] displayOe,
    output logic [pin_mux_pkg::VID_W-1:0] displayIn,
    input wire pin_mux_pkg::ext_bus_t extBus,
    input wire logic [pin_mux_pkg::STOR_W-1:0] storagePadIn,
    output logic [pin_mux_pkg::STOR_W-1:0] storagePadOut,
    output logic [pin_mux_pkg::STOR_W-1:0] storagePadOe,
    input wire logic [pin_mux_pkg::STOR_W-1:0] generalIoOut,
    input wire logic [pin_mux_pkg::STOR_W-1:0] generalIoOe,
    output logic [pin_mux_pkg::STOR_W-1:0] generalIoIn,
    input wire logic [pin_mux_pkg::STOR_W-1:0] cardLowOut,
    input wire logic [pin_mux_pkg::STOR_W-1:0] cardLowOe,
    output logic [pin_mux_pkg::STOR_W-1:0] cardLowIn,
    input wire logic [pin_mux_pkg::FLASH_W-1:0] flashPadIn,
    output logic [pin_mux_pkg::FLASH_W-1:0] flashPadOut,
    output logic [pin_mux_pkg::FLASH_W-1:0] flashPadOe,
    output logic [pin_mux_pkg::FLASH_W-1:0] flashReadyBusy,
    input wire logic [pin_mux_pkg::FLASH_W-1:0] cardHighOut,
    input wire logic [pin_mux_pkg::FLASH_W-1:0] cardHighOe,
    output logic [pin_mux_pkg::FLASH_W-1:0] cardHighIn,
    input wire logic [pin_mux_pkg::AUD_W-1:0] audioPadIn,
    output logic [pin_mux_pkg::AUD_W-1:0] audioPadOut,
    output logic [pin_mux_pkg::AUD_W-1:0] audioPadOe,
    input wire logic [pin_mux_pkg::AUD_W-1:0] audioTxOut,
    input wire pin_mux_pkg::telephony_t telephonyOut,
    input wire pin_mux_pkg::telephony_t telephonyOe,
    output var pin_mux_pkg::telephony_t telephonyIn,
    input wire logic [pin_mux_pkg::UART_W-1:0] uartPadIn,
    output logic [pin_mux_pkg::UART_W-1:0] uartPadOut,
    output logic [pin_mux_pkg::UART_W-1:0] uartPadOe,
    input wire logic uartRequestToSendN,
    output logic uartClearToSendN,
    input wire logic serialPeriphSelect1,
    input wire logic serialPeriphSelect2
);
    import pin_mux_pkg::*;

    logic rstMeta;
    logic rstn;
    group_sel_t next_activeMode;
    logic [VID_W-1:0] videoAltOut;
    logic [AUD_W-1:0] audioAltOut;
    logic [AUD_W-1:0] audioAltOe;
    logic [AUD_W-1:0] telephonyInVec;
    logic [UART_W-1:0] uartDefaultOut;
    logic [UART_W-1:0] uartDefaultOe;
    logic [UART_W-1:0] uartSerialOut;
    logic [UART_W-1:0] uartDefaultIn;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstn <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstn <= rstMeta;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ----------------------------------------
    // Group selection
    // ----------------------------------------
    // Control register bits sit on this clock; one register stage only
    always_comb
    begin
        next_activeMode = modeRequest;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            activeMode <= SEL_RESET;
        end
        else
        begin
            activeMode <= next_activeMode;
        end
    end

    chk_reset_default: assert property (
        $rose(rstn) |-> activeMode == SEL_RESET && videoPadOe == '0)
        else $error("group not in default mode after reset");

    // ----------------------------------------
    // Video group
    // ----------------------------------------
    // Memory bus signals are pure outputs, so in alternate mode the pads are always driven
    always_comb
    begin
        videoAltOut = '0;
        videoAltOut[ADDR_HI:ADDR_LO] = extBus.address;
        videoAltOut[VID_PAD_DB1] = extBus.staticCs1;
        videoAltOut[VID_PAD_DB0] = extBus.dramClockOut;
        videoAltOut[VID_PAD_CS] = extBus.staticCs0;
        videoAltOut[VID_PAD_ERD] = extBus.dramClockEnable;
        videoAltOut[VID_PAD_RS] = extBus.dramChipSelect;
        videoAltOut[VID_PAD_WR] = extBus.dramDataMask1;
    end

    pin_mux_slice #(.W(VID_W), .IDLE_A(DISP_IDLE), .IDLE_B(DISP_IDLE))
    videoSlice (
        .clk(clk), .rstn(rstn),
        .sel(activeMode.video == MODE_ALT),
        .aOut(displayOut),
        .aOe(displayOe),
        .bOut(videoAltOut),
        .bOe({VID_W{1'b1}}),
        .padIn(videoPadIn),
        .padOut(videoPadOut),
        .padOe(videoPadOe),
        .aIn(displayIn), .bIn()
    );

    chk_video_cs: assert property (
        $past(rstn) |-> videoPadOut[VID_PAD_CS] ==
            ($past(activeMode.video) == MODE_ALT ?
             $past(extBus.staticCs0) : $past(displayOut[VID_PAD_CS])))
        else $error("display select pin carries wrong source");
    chk_video_db1: assert property (
        $past(rstn) && $past(activeMode.video) == MODE_ALT |->
            videoPadOut[VID_PAD_DB1] == $past(extBus.staticCs1)
            && videoPadOe[VID_PAD_DB1])
        else $error("data line 1 does not carry static select 1");
    chk_video_db0: assert property (
        $past(rstn) && $past(activeMode.video) == MODE_ALT |->
            videoPadOut[VID_PAD_DB0] == $past(extBus.dramClockOut))
        else $error("data line 0 does not carry memory clock");
    chk_video_erd: assert property (
        $past(rstn) && $past(activeMode.video) == MODE_ALT |->
            videoPadOut[VID_PAD_ERD] == $past(extBus.dramClockEnable))
        else $error("strobe pin does not carry clock enable");
    chk_video_rs: assert property (
        $past(rstn) |-> videoPadOut[VID_PAD_RS] ==
            ($past(activeMode.video) == MODE_ALT ?
             $past(extBus.dramChipSelect) : $past(displayOut[VID_PAD_RS]))
            && videoPadOe[VID_PAD_RS] == ($past(displayOe[VID_PAD_RS])
            || $past(activeMode.video) == MODE_ALT))
        else $error("register select pin carries wrong source");
    chk_video_wr: assert property (
        $past(rstn) && $past(activeMode.video) == MODE_ALT |->
            videoPadOut[VID_PAD_WR] == $past(extBus.dramDataMask1))
        else $error("write strobe pin does not carry data mask");
    chk_video_addr: assert property (
        $past(rstn) && $past(activeMode.video) == MODE_ALT |->
            videoPadOut[ADDR_HI:ADDR_LO] == $past(extBus.address))
        else $error("address bits misplaced on display data pins");

    // ----------------------------------------
    // Storage group
    // ----------------------------------------
    // Card clock, command and data 0-3 in pad order
    pin_mux_slice #(.W(STOR_W), .IDLE_A(GPIO_IDLE), .IDLE_B(CARD_LO_IDLE))
    storageSlice (
        .clk(clk), .rstn(rstn),
        .sel(activeMode.storage == MODE_ALT),
        .aOut(generalIoOut),
        .aOe(generalIoOe),
        .bOut(cardLowOut),
        .bOe(cardLowOe),
        .padIn(storagePadIn),
        .padOut(storagePadOut),
        .padOe(storagePadOe),
        .aIn(generalIoIn), .bIn(cardLowIn)
    );

    chk_storage_card: assert property (
        $past(rstn, 3) && $past(activeMode.storage) == MODE_ALT |->
            cardLowIn == $past(storagePadIn, 3)
            && storagePadOe == $past(cardLowOe))
        else $error("card lines not routed to general pins");

    // ----------------------------------------
    // Flash group
    // ----------------------------------------
    // Independent of the video choice, so flash stays usable in both
    pin_mux_slice #(.W(FLASH_W), .IDLE_A(READY_IDLE), .IDLE_B(CARD_HI_IDLE))
    flashSlice (
        .clk(clk), .rstn(rstn),
        .sel(activeMode.flash == MODE_ALT),
        .aOut({FLASH_W{1'b0}}),
        .aOe({FLASH_W{1'b0}}),
        .bOut(cardHighOut),
        .bOe(cardHighOe),
        .padIn(flashPadIn),
        .padOut(flashPadOut),
        .padOe(flashPadOe),
        .aIn(flashReadyBusy), .bIn(cardHighIn)
    );

    chk_flash_card: assert property (
        $past(rstn) && $past(activeMode.flash) == MODE_ALT |->
            flashPadOut == $past(cardHighOut)
            && flashPadOe == $past(cardHighOe))
        else $error("card data 4-7 not routed to ready pins");
    chk_flash_reach: assert property (
        $past(rstn, 3) && $past(activeMode.flash) == MODE_DEFAULT |->
            flashReadyBusy == $past(flashPadIn, 3) && flashPadOe == '0)
        else $error("flash ready lines lost");

    // ----------------------------------------
    // Audio group
    // ----------------------------------------
    always_comb
    begin
        audioAltOut[AUD_PAD_DATA] = telephonyOut.dataA;
        audioAltOut[AUD_PAD_MCLK] = telephonyOut.dataB;
        audioAltOut[AUD_PAD_BCK] = telephonyOut.frameSync;
        audioAltOut[AUD_PAD_WS] = telephonyOut.dataClock;
        audioAltOe[AUD_PAD_DATA] = telephonyOe.dataA;
        audioAltOe[AUD_PAD_MCLK] = telephonyOe.dataB;
        audioAltOe[AUD_PAD_BCK] = telephonyOe.frameSync;
        audioAltOe[AUD_PAD_WS] = telephonyOe.dataClock;
    end

    pin_mux_slice #(.W(AUD_W), .IDLE_A(AUD_IDLE), .IDLE_B(TEL_IDLE))
    audioSlice (
        .clk(clk), .rstn(rstn),
        .sel(activeMode.audio == MODE_ALT),
        .aOut(audioTxOut),
        .aOe({AUD_W{1'b1}}),
        .bOut(audioAltOut),
        .bOe(audioAltOe),
        .padIn(audioPadIn),
        .padOut(audioPadOut),
        .padOe(audioPadOe),
        .aIn(), .bIn(telephonyInVec)
    );

    // Same pad order as the outgoing side
    always_comb
    begin
        telephonyIn.dataA = telephonyInVec[AUD_PAD_DATA];
        telephonyIn.dataB = telephonyInVec[AUD_PAD_MCLK];
        telephonyIn.frameSync = telephonyInVec[AUD_PAD_BCK];
        telephonyIn.dataClock = telephonyInVec[AUD_PAD_WS];
    end

    chk_audio_data: assert property (
        $past(rstn) && $past(activeMode.audio) == MODE_ALT |->
            audioPadOut[AUD_PAD_DATA] == $past(telephonyOut.dataA)
            && audioPadOut[AUD_PAD_MCLK] == $past(telephonyOut.dataB))
        else $error("telephony data lines misplaced");
    chk_audio_clock: assert property (
        $past(rstn) && $past(activeMode.audio) == MODE_ALT |->
            audioPadOut[AUD_PAD_BCK] == $past(telephonyOut.frameSync)
            && audioPadOut[AUD_PAD_WS] == $past(telephonyOut.dataClock))
        else $error("telephony sync or clock misplaced");

    // ----------------------------------------
    // Serial group
    // ----------------------------------------
    // Clear-to-send is an input, request-to-send an output
    always_comb
    begin
        uartDefaultOut = '0;
        uartDefaultOe = '0;
        uartDefaultOut[UART_PAD_RTS] = uartRequestToSendN;
        uartDefaultOe[UART_PAD_RTS] = 1'b1;
        uartSerialOut[UART_PAD_CTS] = serialPeriphSelect1;
        uartSerialOut[UART_PAD_RTS] = serialPeriphSelect2;
    end

    pin_mux_slice #(.W(UART_W), .IDLE_A(UART_IDLE), .IDLE_B(SPI_IDLE))
    uartSlice (
        .clk(clk), .rstn(rstn),
        .sel(activeMode.uart == MODE_ALT),
        .aOut(uartDefaultOut),
        .aOe(uartDefaultOe),
        .bOut(uartSerialOut),
        .bOe({UART_W{1'b1}}),
        .padIn(uartPadIn),
        .padOut(uartPadOut),
        .padOe(uartPadOe),
        .aIn(uartDefaultIn), .bIn()
    );

    assign uartClearToSendN = uartDefaultIn[UART_PAD_CTS];

    chk_uart_select: assert property (
        $past(rstn) && $past(activeMode.uart) == MODE_ALT |->
            uartPadOut == {$past(serialPeriphSelect2),
                           $past(serialPeriphSelect1)}
            && uartPadOe == 2'h3)
        else $error("serial selects not on modem pins");
    chk_uart_modem: assert property (
        $past(rstn) && $past(activeMode.uart) == MODE_DEFAULT |->
            uartPadOe == 2'h2
            && uartPadOut[UART_PAD_RTS] == $past(uartRequestToSendN))
        else $error("modem pins not in flow control use");

endmodule
`default_nettype wire

// >>> bench/pad_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module pad_far_end
#(
    parameter int W = 1
)
(
    input wire logic [W-1:0] padOut,
    input wire logic [W-1:0] padOe,
    input wire logic [W-1:0] extDrive,
    output logic [W-1:0] padIn
);
    // ----------------------------------------
    // Pad wire resolution
    // ----------------------------------------
    // Far side drives only where the device lets go, so a released pad
    // shows the far side's own value, never the device's stale one
    assign padIn = (padOe & padOut) | (~padOe & extDrive);
endmodule
`default_nettype wire

// >>> bench/shared_pin_function_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module shared_pin_function_mux_tb_top;
    import pin_mux_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    group_sel_t modeRequest = SEL_RESET;
    group_sel_t activeMode;
    logic [VID_W-1:0] videoPadIn, videoPadOut, videoPadOe, displayIn;
    logic [VID_W-1:0] displayOut = '0, displayOe = '0, vidExt = '0;
    ext_bus_t extBus = '0;
    logic [STOR_W-1:0] storagePadIn, storagePadOut, storagePadOe;
    logic [STOR_W-1:0] generalIoIn, cardLowIn, stoExt = '0;
    logic [STOR_W-1:0] generalIoOut = '0, generalIoOe = '0;
    logic [STOR_W-1:0] cardLowOut = '0, cardLowOe = '0;
    logic [FLASH_W-1:0] flashPadIn, flashPadOut, flashPadOe;
    logic [FLASH_W-1:0] flashReadyBusy, cardHighIn, flExt = '0;
    logic [FLASH_W-1:0] cardHighOut = '0, cardHighOe = '0;
    logic [AUD_W-1:0] audioPadIn, audioPadOut, audioPadOe;
    logic [AUD_W-1:0] audioTxOut = '0, audExt = '0;
    telephony_t telephonyOut = '0, telephonyOe = '0, telephonyIn;
    logic [UART_W-1:0] uartPadIn, uartPadOut, uartPadOe, uartExt = '0;
    logic uartRequestToSendN = 1'b1;
    logic uartClearToSendN;
    logic serialPeriphSelect1 = 1'b1;
    logic serialPeriphSelect2 = 1'b1;
    int failCount = 0;
    int cmpCount = 0;

    shared_pin_function_mux dut (.clk(clk), .resetn(resetn),
        .modeRequest(modeRequest), .activeMode(activeMode),
        .videoPadIn(videoPadIn), .videoPadOut(videoPadOut),
        .videoPadOe(videoPadOe), .displayOut(displayOut),
        .displayOe(displayOe), .displayIn(displayIn), .extBus(extBus),
        .storagePadIn(storagePadIn), .storagePadOut(storagePadOut),
        .storagePadOe(storagePadOe), .generalIoOut(generalIoOut),
        .generalIoOe(generalIoOe), .generalIoIn(generalIoIn),
        .cardLowOut(cardLowOut), .cardLowOe(cardLowOe),
        .cardLowIn(cardLowIn), .flashPadIn(flashPadIn),
        .flashPadOut(flashPadOut), .flashPadOe(flashPadOe),
        .flashReadyBusy(flashReadyBusy), .cardHighOut(cardHighOut),
        .cardHighOe(cardHighOe), .cardHighIn(cardHighIn),
        .audioPadIn(audioPadIn), .audioPadOut(audioPadOut),
        .audioPadOe(audioPadOe), .audioTxOut(audioTxOut),
        .telephonyOut(telephonyOut), .telephonyOe(telephonyOe),
        .telephonyIn(telephonyIn), .uartPadIn(uartPadIn),
        .uartPadOut(uartPadOut), .uartPadOe(uartPadOe),
        .uartRequestToSendN(uartRequestToSendN),
        .uartClearToSendN(uartClearToSendN),
        .serialPeriphSelect1(serialPeriphSelect1),
        .serialPeriphSelect2(serialPeriphSelect2));

    pad_far_end #(.W(VID_W)) farVid (.padOut(videoPadOut),
        .padOe(videoPadOe), .extDrive(vidExt), .padIn(videoPadIn));
    pad_far_end #(.W(STOR_W)) farSto (.padOut(storagePadOut),
        .padOe(storagePadOe), .extDrive(stoExt), .padIn(storagePadIn));
    pad_far_end #(.W(FLASH_W)) farFl (.padOut(flashPadOut),
        .padOe(flashPadOe), .extDrive(flExt), .padIn(flashPadIn));
    pad_far_end #(.W(AUD_W)) farAud (.padOut(audioPadOut),
        .padOe(audioPadOe), .extDrive(audExt), .padIn(audioPadIn));
    pad_far_end #(.W(UART_W)) farUart (.padOut(uartPadOut),
        .padOe(uartPadOe), .extDrive(uartExt), .padIn(uartPadIn));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [19:0] res(input logic [19:0] oe,
        input logic [19:0] out, input logic [19:0] ext);
        return (oe & out) | (~oe & ext);
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic cmp(input string what, input logic [19:0] exp,
        input logic [19:0] got);
        cmpCount++;
        if (exp !== got)
        begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic endSim();
        if (failCount == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic shake(input logic [4:0] m);
        modeRequest = group_sel_t'(m);
        displayOut = 20'($urandom);
        displayOe = 20'($urandom);
        extBus = ext_bus_t'(20'($urandom));
        generalIoOut = 6'($urandom);
        generalIoOe = 6'($urandom);
        cardLowOut = 6'($urandom);
        cardLowOe = 6'($urandom);
        cardHighOut = 4'($urandom);
        cardHighOe = 4'($urandom);
        audioTxOut = 4'($urandom);
        telephonyOut = telephony_t'(4'($urandom));
        telephonyOe = telephony_t'(4'($urandom));
        uartRequestToSendN = 1'($urandom);
        serialPeriphSelect1 = 1'($urandom);
        serialPeriphSelect2 = 1'($urandom);
        vidExt = 20'($urandom);
        stoExt = 6'($urandom);
        flExt = 4'($urandom);
        audExt = 4'($urandom);
        uartExt = 2'($urandom);
    endtask

    // ----------------------------------------
    // Settled-state expectation of every port
    // ----------------------------------------
    task automatic check_all();
        logic [19:0] eo;
        logic [19:0] ee;
        logic [19:0] r;
        group_sel_t m;
        m = modeRequest;
        cmp("activeMode", {15'h0000, m}, {15'h0000, activeMode});
        eo = m.video ? {extBus.dramDataMask1, extBus.dramChipSelect,
            extBus.dramClockEnable, extBus.staticCs0, extBus.address,
            extBus.staticCs1, extBus.dramClockOut} : displayOut;
        ee = m.video ? 20'hF_FFFF : displayOe;
        cmp("videoPadOe", ee, videoPadOe);
        cmp("videoPadOut", eo & ee, videoPadOut & ee);
        r = res(ee, eo, vidExt);
        cmp("displayIn", m.video ? 20'h0_0000 : r, displayIn);
        eo = m.storage ? cardLowOut : generalIoOut;
        ee = m.storage ? cardLowOe : generalIoOe;
        cmp("storagePadOe", ee, storagePadOe);
        cmp("storagePadOut", eo & ee, storagePadOut & ee);
        r = res(ee, eo, stoExt);
        cmp("generalIoIn", m.storage ? 20'h0_0000 : r, generalIoIn);
        cmp("cardLowIn", m.storage ? r : CARD_LO_IDLE, cardLowIn);
        eo = m.flash ? cardHighOut : 4'h0;
        ee = m.flash ? cardHighOe : 4'h0;
        cmp("flashPadOe", ee, flashPadOe);
        cmp("flashPadOut", eo & ee, flashPadOut & ee);
        r = res(ee, eo, flExt);
        cmp("flashReadyBusy", m.flash ? READY_IDLE : r, flashReadyBusy);
        cmp("cardHighIn", m.flash ? r : CARD_HI_IDLE, cardHighIn);
        eo = m.audio ? {telephonyOut} : audioTxOut;
        ee = m.audio ? {telephonyOe} : 4'hF;
        cmp("audioPadOe", ee, audioPadOe);
        cmp("audioPadOut", eo & ee, audioPadOut & ee);
        r = res(ee, eo, audExt);
        cmp("telephonyIn", m.audio ? r : 20'h0_0000, {telephonyIn});
        eo = m.uart ? {serialPeriphSelect2, serialPeriphSelect1}
            : {uartRequestToSendN, 1'b0};
        ee = m.uart ? 2'h3 : 2'h2;
        cmp("uartPadOe", ee, uartPadOe);
        cmp("uartPadOut", eo & ee, uartPadOut & ee);
        r = res(ee, eo, uartExt);
        cmp("uartClearToSendN", m.uart ? 1'b1 : r[0], uartClearToSendN);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h33b1));
        // Alternate asked during reset must not leak out
        modeRequest = group_sel_t'(5'h1F);
        step(2);
        cmp("activeMode", 20'h0_0000, {15'h0000, activeMode});
        cmp("videoPadOe", 20'h0_0000, videoPadOe);
        resetn = 1'b1;
        modeRequest = SEL_RESET;
        step(8);
        check_all();
        for (int i = 0; i < 80; i++)
        begin
            shake(i == 0 ? 5'h1F : i == 1 ? 5'h0A : 5'($urandom));
            step(6);
            check_all();
        end
        // Mode change latency: register first, pads one cycle later
        displayOe = 20'h0_0F0F;
        modeRequest.video = MODE_DEFAULT;
        step(6);
        modeRequest.video = MODE_ALT;
        step(1);
        cmp("activeMode", {15'h0000, modeRequest}, {15'h0000, activeMode});
        cmp("videoPadOe", 20'h0_0F0F, videoPadOe);
        step(1);
        cmp("videoPadOe", 20'hF_FFFF, videoPadOe);
        // Reset in mid-run acts at once and restores defaults
        resetn = 1'b0;
        #1;
        cmp("activeMode", 20'h0_0000, {15'h0000, activeMode});
        cmp("videoPadOe", 20'h0_0000, videoPadOe);
        step(2);
        resetn = 1'b1;
        step(8);
        check_all();
        endSim();
    end
endmodule
`default_nettype wire
